// ---- mode_pkg.sv ----
package mode_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ = 250;
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int PRESS_GAP_MS = 1000;
  localparam int PRESS_GAP_CYC = PRESS_GAP_MS * 1000 * CLK_MHZ;
  localparam int FAST_BLINK_MS = 100;
  localparam int FAST_HALF_CYC = FAST_BLINK_MS * 1000 * CLK_MHZ / 2;
  localparam int SLOW_BLINK_MS = 1000;
  localparam int SLOW_HALF_CYC = SLOW_BLINK_MS * 1000 * CLK_MHZ / 2;
  localparam logic [2:0] FACTORY_PRESSES = 3'h5;
  // ************************************************************
  // default access point settings and trigger code
  // ************************************************************
  localparam logic [7:0] SETUP_TRIGGER_CODE = 8'h10;
  localparam logic [3:0] AP_CHANNEL = 4'h1;
  localparam logic [31:0] AP_ADDRESS = 32'h01020304;
  localparam logic [31:0] AP_MASK = 32'hFFFFFF00;
  localparam logic [31:0] AP_GATEWAY = 32'h01020304;
  typedef enum logic [1:0] {LED_OFF, LED_FAST, LED_SLOW, LED_ON} led_mode_t;
  typedef enum {ST_BOOT, ST_CLIENT, ST_AP} op_state_t;
endpackage

// ---- debounce_if.sv ----
interface debounce_if;
  logic raw;
  logic level;
  logic rise;
  modport filt(input raw, output level, output rise);
  modport user(output raw, input level, input rise);
endinterface

// ---- debounce.sv ----
module debounce
  import mode_pkg::*;
#(
  parameter int CYCLES = DEBOUNCE_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  debounce_if.filt db
);
  logic sync_a;
  logic sync_b;
  logic [31:0] cnt;
  wire differs = (sync_b != db.level);
  wire settled = (cnt >= 32'(CYCLES - 1));
  // two-stage sampler, then level must hold steady before it is accepted
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      cnt <= 32'h0;
      db.level <= 1'b0;
      db.rise <= 1'b0;
    end else begin
      sync_a <= db.raw;
      sync_b <= sync_a;
      db.rise <= 1'b0;
      if (!differs) begin
        cnt <= 32'h0;
      end else if (settled) begin
        cnt <= 32'h0;
        db.level <= sync_b;
        db.rise <= sync_b;
      end else begin
        cnt <= cnt + 32'h1;
      end
    end
  end
endmodule

// ---- mode_select_and_status_leds.sv ----
module mode_select_and_status_leds
  import mode_pkg::*;
#(
  parameter int DEB_CYC = DEBOUNCE_CYC,
  parameter int GAP_CYC = PRESS_GAP_CYC,
  parameter int FAST_CYC = FAST_HALF_CYC,
  parameter int SLOW_CYC = SLOW_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic mode_button_line,
  input wire logic reset_button,
  input wire logic wake,
  input wire logic trigger_write,
  input wire logic [7:0] trigger_value,
  input wire logic associated,
  input wire logic internet_ok,
  input wire logic data_active,
  input wire logic address_held,
  input wire logic tcp_open,
  output logic ap_mode,
  output logic apply_defaults,
  output logic [3:0] net_channel,
  output logic dhcp_server_en,
  output logic [31:0] net_address,
  output logic [31:0] net_mask,
  output logic [31:0] net_gateway,
  output logic factory_restore,
  output logic setup_start,
  output logic reboot,
  output logic led_red,
  output logic led_yellow,
  output logic led_green,
  output logic led_blue
);
  // ************************************************************
  // debounced buttons
  // ************************************************************
  debounce_if mode_db();
  debounce_if rst_db();
  assign mode_db.raw = mode_button_line;
  assign rst_db.raw = reset_button;
  debounce #(.CYCLES(DEB_CYC)) u_mode_db (.core_clk(core_clk), .arst_n(arst_n), .db(mode_db));
  debounce #(.CYCLES(DEB_CYC)) u_rst_db (.core_clk(core_clk), .arst_n(arst_n), .db(rst_db));

  // ************************************************************
  // operating mode
  // ************************************************************
  op_state_t state;
  logic boot_pending;
  logic mode_seen;
  logic setup_enabled;
  logic [2:0] press_cnt;
  logic [31:0] gap_cnt;
  wire gap_ok = (gap_cnt >= 32'(GAP_CYC));
  wire trig_hit = trigger_write && (trigger_value == SETUP_TRIGGER_CODE);
  // boot sample waits one debounce window plus two sampler cycles so the filtered level is valid
  wire boot_ready = (gap_cnt >= 32'(DEB_CYC + 2));
  wire ap_press_ok = mode_db.rise && (press_cnt == 3'h0 || gap_ok);

  // mode state, sampling at boot and wake; reset press causes a reboot
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_BOOT;
      boot_pending <= 1'b1;
      mode_seen <= 1'b0;
      apply_defaults <= 1'b0;
      reboot <= 1'b0;
    end else begin
      apply_defaults <= 1'b0;
      reboot <= 1'b0;
      if (mode_db.rise) begin
        mode_seen <= 1'b1; // remembered for the next reboot
      end
      if (rst_db.rise) begin
        reboot <= 1'b1;
        state <= ST_BOOT;
        boot_pending <= 1'b1;
      end else if (wake) begin
        state <= ST_BOOT;
        boot_pending <= 1'b1;
      end else if (state == ST_BOOT && boot_ready && boot_pending) begin
        boot_pending <= 1'b0;
        mode_seen <= 1'b0;
        if (mode_db.level || mode_seen) begin
          state <= ST_AP;
          apply_defaults <= 1'b1;
        end else begin
          state <= ST_CLIENT;
        end
      end
    end
  end

  // press counting in AP mode, gap timer shared with boot wait
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      press_cnt <= 3'h0;
      gap_cnt <= 32'h0;
      factory_restore <= 1'b0;
    end else begin
      factory_restore <= 1'b0;
      if (!gap_ok || state == ST_BOOT) begin
        gap_cnt <= gap_cnt + 32'h1;
      end
      if (state != ST_AP) begin
        press_cnt <= 3'h0;
        if (state != ST_BOOT) begin
          gap_cnt <= 32'h0;
        end
      end else if (mode_db.rise) begin
        gap_cnt <= 32'h0;
        if (!ap_press_ok) begin
          press_cnt <= 3'h1; // too soon: this press starts a new series
        end else if (press_cnt == FACTORY_PRESSES - 3'h1) begin
          press_cnt <= 3'h0;
          factory_restore <= 1'b1;
        end else begin
          press_cnt <= press_cnt + 3'h1;
        end
      end
      if (rst_db.rise || wake) begin
        gap_cnt <= 32'h0;
      end
    end
  end

  // setup enable, then client-mode press starts setup
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      setup_enabled <= 1'b0;
      setup_start <= 1'b0;
    end else begin
      if (trig_hit) begin
        setup_enabled <= 1'b1;
      end
      setup_start <= (state == ST_CLIENT) && setup_enabled && mode_db.rise;
    end
  end

  // network defaults are held while in AP mode
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ap_mode <= 1'b0;
      net_channel <= 4'h0;
      dhcp_server_en <= 1'b0;
      net_address <= 32'h0;
      net_mask <= 32'h0;
      net_gateway <= 32'h0;
    end else begin
      ap_mode <= (state == ST_AP);
      net_channel <= (state == ST_AP) ? AP_CHANNEL : 4'h0;
      dhcp_server_en <= (state == ST_AP);
      net_address <= (state == ST_AP) ? AP_ADDRESS : 32'h0;
      net_mask <= (state == ST_AP) ? AP_MASK : 32'h0;
      net_gateway <= (state == ST_AP) ? AP_GATEWAY : 32'h0;
    end
  end

  // ************************************************************
  // indicators
  // ************************************************************
  logic [31:0] fast_cnt;
  logic [31:0] slow_cnt;
  logic fast_ph;
  logic slow_ph;
  function automatic logic led_level(led_mode_t m, logic f, logic s);
    case (m)
      LED_FAST: led_level = f;
      LED_SLOW: led_level = s;
      LED_ON: led_level = 1'b1;
      default: led_level = 1'b0;
    endcase
  endfunction
  wire led_mode_t red_mode = !associated ? LED_FAST : (!internet_ok ? LED_SLOW : LED_OFF);
  wire led_mode_t yel_mode = data_active ? LED_FAST : LED_OFF;
  wire led_mode_t grn_mode = tcp_open ? LED_ON : (address_held ? LED_SLOW : LED_FAST);

  // free-running blink phases; a shorter fast period gives the quicker flash
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fast_cnt <= 32'h0;
      slow_cnt <= 32'h0;
      fast_ph <= 1'b0;
      slow_ph <= 1'b0;
    end else begin
      fast_cnt <= (fast_cnt >= 32'(FAST_CYC - 1)) ? 32'h0 : fast_cnt + 32'h1;
      slow_cnt <= (slow_cnt >= 32'(SLOW_CYC - 1)) ? 32'h0 : slow_cnt + 32'h1;
      if (fast_cnt >= 32'(FAST_CYC - 1)) begin
        fast_ph <= ~fast_ph;
      end
      if (slow_cnt >= 32'(SLOW_CYC - 1)) begin
        slow_ph <= ~slow_ph;
      end
    end
  end

  // led outputs registered
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      led_red <= 1'b0;
      led_yellow <= 1'b0;
      led_green <= 1'b0;
      led_blue <= 1'b0;
    end else begin
      led_red <= led_level(red_mode, fast_ph, slow_ph);
      led_yellow <= led_level(yel_mode, fast_ph, slow_ph);
      led_green <= led_level(grn_mode, fast_ph, slow_ph);
      led_blue <= 1'b0; // unused
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_setup;
    @(posedge core_clk) disable iff (!arst_n)
      setup_start |-> $past(setup_enabled) && $past(state == ST_CLIENT);
  endproperty
  a_setup: assert property (p_setup) else $error("setup without enable or in AP");
  property p_defaults;
    @(posedge core_clk) disable iff (!arst_n)
      ap_mode |-> net_address == AP_ADDRESS && net_mask == AP_MASK && net_channel == AP_CHANNEL;
  endproperty
  a_defaults: assert property (p_defaults) else $error("AP defaults wrong");
  property p_apply;
    @(posedge core_clk) disable iff (!arst_n)
      apply_defaults |=> ap_mode;
  endproperty
  a_apply: assert property (p_apply) else $error("defaults without AP mode");
  property p_factory;
    @(posedge core_clk) disable iff (!arst_n)
      factory_restore |-> $past(state == ST_AP) && $past(mode_db.rise);
  endproperty
  a_factory: assert property (p_factory) else $error("factory restore without press");
  property p_reboot;
    @(posedge core_clk) disable iff (!arst_n)
      rst_db.rise |=> reboot && state == ST_BOOT;
  endproperty
  a_reboot: assert property (p_reboot) else $error("reset press did not reboot");
  property p_boot_ap;
    @(posedge core_clk) disable iff (!arst_n)
      (state == ST_BOOT && boot_pending && boot_ready && mode_db.level && !rst_db.rise && !wake)
        |=> state == ST_AP;
  endproperty
  a_boot_ap: assert property (p_boot_ap) else $error("high mode line did not give AP");
  property p_red_off;
    @(posedge core_clk) disable iff (!arst_n)
      (associated && internet_ok) [*2] |-> !led_red;
  endproperty
  a_red_off: assert property (p_red_off) else $error("red lit with internet");
  property p_green_on;
    @(posedge core_clk) disable iff (!arst_n)
      tcp_open [*2] |-> led_green;
  endproperty
  a_green_on: assert property (p_green_on) else $error("green not solid with TCP");
  property p_blue;
    @(posedge core_clk) disable iff (!arst_n) !led_blue;
  endproperty
  a_blue: assert property (p_blue) else $error("blue lit");
  c_factory: cover property (@(posedge core_clk) disable iff (!arst_n) factory_restore);
  c_setup: cover property (@(posedge core_clk) disable iff (!arst_n) setup_start);
  c_ap: cover property (@(posedge core_clk) disable iff (!arst_n) apply_defaults);
endmodule

// ---- button_host_model.sv ----
// ************************************************************
// pushbuttons and host console standing in front of the block
// ************************************************************
module button_host_model #(
  parameter int HOLD = 8
) (
  input wire logic core_clk,
  output logic mode_button_line,
  output logic reset_button,
  output logic trigger_write,
  output logic [7:0] trigger_value
);
  timeunit 1ns;
  timeprecision 100ps;

  // released buttons fall back to low through their pull-downs
  initial begin
    mode_button_line = 1'b0;
    reset_button = 1'b0;
    trigger_write = 1'b0;
    trigger_value = 8'h00;
  end

  // a press is held long enough to pass the debounce filter, then released as long
  task automatic press(input bit rst_btn);
    @(posedge core_clk);
    #1;
    reset_button = rst_btn;
    mode_button_line = !rst_btn;
    repeat (HOLD) @(posedge core_clk);
    #1;
    reset_button = 1'b0;
    mode_button_line = 1'b0;
    repeat (HOLD) @(posedge core_clk);
    #1;
  endtask

  // a blip shorter than the debounce window must never count as a press
  task automatic glitch;
    @(posedge core_clk);
    #1;
    mode_button_line = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    mode_button_line = 1'b0;
    repeat (HOLD) @(posedge core_clk);
    #1;
  endtask

  // operator holds the mode button for a boot sample
  task automatic set_mode(input logic v);
    @(posedge core_clk);
    #1;
    mode_button_line = v;
  endtask

  // one-cycle console write; value is scrambled once the strobe drops
  task automatic write_trigger(input logic [7:0] v);
    @(posedge core_clk);
    #1;
    trigger_value = v;
    trigger_write = 1'b1;
    @(posedge core_clk);
    #1;
    trigger_write = 1'b0;
    trigger_value = ~v;
  endtask
endmodule

// ---- testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEB = 4;
  localparam int GAP = 40;
  localparam int FAST = 8;
  localparam int SLOW = 32;
  localparam int BOOT = DEB + 8;
  logic core_clk, arst_n, mode_button_line, reset_button, wake, trigger_write;
  logic [7:0] trigger_value;
  logic associated, internet_ok, data_active, address_held, tcp_open;
  logic ap_mode, apply_defaults, dhcp_server_en, factory_restore, setup_start, reboot;
  logic led_red, led_yellow, led_green, led_blue;
  logic [3:0] net_channel;
  logic [31:0] net_address, net_mask, net_gateway;
  int failures = 0;
  int num_checks = 0;
  int n_def = 0;
  int n_fac = 0;
  int n_set = 0;
  int n_rb = 0;

  mode_select_and_status_leds #(.DEB_CYC(DEB), .GAP_CYC(GAP), .FAST_CYC(FAST),
    .SLOW_CYC(SLOW)) dut (.core_clk(core_clk), .arst_n(arst_n),
    .mode_button_line(mode_button_line), .reset_button(reset_button), .wake(wake),
    .trigger_write(trigger_write), .trigger_value(trigger_value), .associated(associated),
    .internet_ok(internet_ok), .data_active(data_active), .address_held(address_held),
    .tcp_open(tcp_open), .ap_mode(ap_mode), .apply_defaults(apply_defaults),
    .net_channel(net_channel), .dhcp_server_en(dhcp_server_en), .net_address(net_address),
    .net_mask(net_mask), .net_gateway(net_gateway), .factory_restore(factory_restore),
    .setup_start(setup_start), .reboot(reboot), .led_red(led_red), .led_yellow(led_yellow),
    .led_green(led_green), .led_blue(led_blue));
  button_host_model #(.HOLD(DEB + 4)) model (.core_clk(core_clk),
    .mode_button_line(mode_button_line), .reset_button(reset_button),
    .trigger_write(trigger_write), .trigger_value(trigger_value));

  // ************************************************************
  // clock, pulse counters and watchdog
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // pulses stand one cycle, so they are tallied on every rising edge
  always @(posedge core_clk) begin
    if (apply_defaults === 1'b1) n_def++;
    if (factory_restore === 1'b1) n_fac++;
    if (setup_start === 1'b1) n_set++;
    if (reboot === 1'b1) n_rb++;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    failures++;
    complete_run();
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic do_reset;
    arst_n = 1'b0;
    repeat (16) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    repeat (BOOT) @(posedge core_clk);
    #1;
  endtask
  // network fields carry the defaults only in access point mode
  task automatic chk_net(input logic ap);
    chk(ap_mode, ap, "mode");
    chk(net_channel, ap ? 4'h1 : 4'h0, "channel");
    chk(dhcp_server_en, ap, "dhcp");
    chk(net_address, ap ? 32'h01020304 : 32'h0, "address");
    chk(net_mask, ap ? 32'hFFFFFF00 : 32'h0, "mask");
    chk(net_gateway, ap ? 32'h01020304 : 32'h0, "gateway");
  endtask
  function automatic logic led(input int i);
    logic [3:0] v;
    v = {led_blue, led_green, led_yellow, led_red};
    return v[i];
  endfunction
  // link status levels come from the network side of the module
  task automatic set_status(input logic [4:0] v);
    {associated, internet_ok, data_active, address_held, tcp_open} = v;
  endtask
  // the first change may be a mode switch, not a blink edge, so two changes
  // align and the third interval is the measured half period
  task automatic half(input int i, input int exp);
    int n;
    logic s;
    repeat (3) begin
      n = 0;
      s = led(i);
      while (led(i) === s && n < 4 * SLOW) begin
        @(posedge core_clk);
        #1;
        n++;
      end
    end
    chk(n, exp, "blink half period");
  endtask
  task automatic steady(input int i, input logic v);
    logic bad;
    bad = 1'b0;
    repeat (2 * SLOW + 4) begin
      @(posedge core_clk);
      #1;
      if (led(i) !== v) bad = 1'b1;
    end
    chk(bad, 1'b0, "steady indicator");
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic client_setup;
    do_reset();
    chk_net(1'b0);
    model.press(1'b0);
    model.write_trigger(8'h11);
    model.press(1'b0);
    chk(n_set, 0, "setup before enable");
    model.write_trigger(8'h10);
    model.press(1'b0);
    chk(n_set, 1, "setup press");
    model.glitch();
    chk(n_set, 1, "glitch filtered");
  endtask
  task automatic reset_toggle;
    do_reset();
    model.press(1'b1);
    repeat (BOOT) @(posedge core_clk);
    #1;
    chk(n_rb, 1, "reboot");
    chk_net(1'b0);
    model.press(1'b0);
    model.press(1'b1);
    repeat (BOOT) @(posedge core_clk);
    #1;
    chk(n_def, 1, "defaults applied");
    chk_net(1'b1);
  endtask
  // an early second press restarts the series, so six presses give one restore
  task automatic factory;
    model.write_trigger(8'h10);
    model.press(1'b0);
    model.press(1'b0);
    repeat (4) begin
      chk(n_fac, 0, "restore too soon");
      repeat (GAP) @(posedge core_clk);
      model.press(1'b0);
    end
    chk(n_fac, 1, "factory restore");
    chk(n_set, 1, "no setup in AP mode");
  endtask
  task automatic wake_ap;
    do_reset();
    model.set_mode(1'b1);
    wake = 1'b1;
    @(posedge core_clk);
    #1;
    wake = 1'b0;
    repeat (BOOT) @(posedge core_clk);
    #1;
    chk_net(1'b1);
    model.set_mode(1'b0);
  endtask
  task automatic leds;
    half(0, FAST);
    half(2, FAST);
    set_status(5'h16);
    half(0, SLOW);
    half(2, SLOW);
    half(1, FAST);
    set_status(5'h1F);
    steady(0, 1'b0);
    steady(2, 1'b1);
    steady(3, 1'b0);
    set_status(5'h1B);
    steady(1, 1'b0);
  endtask

  initial begin
    arst_n = 1'b0;
    wake = 1'b0;
    set_status(5'h00);
    @(posedge core_clk);
    #1;
    client_setup();
    reset_toggle();
    factory();
    wake_ap();
    leds();
    complete_run();
  end
endmodule
